// >>> design/mcg_clock_gen.sv
// oscillator selection, cpu clock divider, wake-up gate, trim register and clock output pin
`timescale 1ns/10ps
module mcg_clock_gen #(
   parameter int WAKE_SETTLE_CYCLES = mcg_pkg::MCG_WAKE_SETTLE_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic warm_rst_i,
   input wire mcg_pkg::mcg_cfg_t cfg_i,
   input wire logic [mcg_pkg::MCG_TRIM_W-1:0] factory_trim_i,
   input wire logic wdog_osc_i,
   input wire logic internal_rc_clock_i,
   input wire logic xtal_osc_i,
   input wire logic external_clock_in_pin_i,
   input wire logic rtc_uses_crystal_i,
   input wire logic wake_i,
   input wire mcg_pkg::mcg_req_t req_i,
   output logic [mcg_pkg::MCG_DATA_W-1:0] reg_rdata_o,
   input wire logic port_pin_out_i,
   input wire logic port_pin_oe_i,
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_o,
   output logic oscillator_clock_tick_o,
   output logic cpu_core_clock_tick_o,
   output logic peripheral_tick_o,
   output logic machine_cycle_tick_o,
   output logic cpu_clock_running_o,
   output logic [mcg_pkg::MCG_TRIM_W-1:0] rc_trim_o
);
   import mcg_pkg::*;

   localparam logic [MCG_WAKE_CNT_W-1:0] SETTLE_LAST = MCG_WAKE_CNT_W'(WAKE_SETTLE_CYCLES - 1);
   localparam logic [MCG_WAKE_CNT_W-1:0] XTAL_OSC_LAST = MCG_WAKE_CNT_W'(MCG_WAKE_XTAL_OSC_CYCLES - 1);
   localparam logic [MCG_WAKE_CNT_W-1:0] OTHER_OSC_LAST = MCG_WAKE_CNT_W'(MCG_WAKE_OTHER_OSC_CYCLES - 1);

   // source pins in select order
   logic [3:0] src_raw;
   logic [3:0] src_level;
   logic [3:0] src_rise;

   mcg_cfg_t cfg_ff;
   logic [MCG_DATA_W-1:0] divisor_ff;
   logic [MCG_TRIM_W-1:0] trim_ff;
   logic clkout_en_ff;
   logic rc_flag_ff;
   logic [MCG_DIV_CNT_W-1:0] div_cnt_ff;
   logic [MCG_DIV_CNT_W-1:0] div_last_ff;
   logic [MCG_DIV_CNT_W-1:0] nxt_div_last;
   mcg_wake_t wake_ff;
   logic [MCG_WAKE_CNT_W-1:0] wake_cnt_ff;
   logic [MCG_WAKE_CNT_W-1:0] osc_last;
   logic osc_tick;
   logic cpu_core_clock_tick;
   logic cpu_core_clock_phase_ff;
   logic clkout_level_ff;
   logic clkout_allowed;
   logic restart;
   logic [MCG_DATA_W-1:0] nxt_rdata;

   assign src_raw[MCG_SRC_WDOG] = wdog_osc_i;
   assign src_raw[MCG_SRC_RC] = internal_rc_clock_i;
   assign src_raw[MCG_SRC_XTAL] = xtal_osc_i;
   assign src_raw[MCG_SRC_EXT] = external_clock_in_pin_i;

   // every oscillator pin is resynchronised before use
   mcg_sync #(
      .W(4)
   ) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .async_i(src_raw),
      .level_o(src_level),
      .rise_o(src_rise)
   );

   // flash configuration caught while power-on reset is held
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cfg_ff <= cfg_i;
      end
   end

   // one oscillator edge per selected source period
   assign osc_tick = src_rise[cfg_ff.source];

   // sequencer restarts after any reset or a wake event
   assign restart = warm_rst_i | wake_i;

   // crystal sources need the longer oscillator count
   assign osc_last = (cfg_ff.source == MCG_SRC_XTAL) ? XTAL_OSC_LAST : OTHER_OSC_LAST;

   // wake-up gate: oscillator cycles first, then fixed settle time
   always_ff @(posedge clock_i) begin
      if (rst_i || restart) begin
         wake_ff <= MCG_WAKE_OSC;
         wake_cnt_ff <= '0;
      end else begin
         unique case (wake_ff)
            MCG_WAKE_OSC: begin
               if (osc_tick) begin
                  if (wake_cnt_ff == osc_last) begin
                     wake_ff <= MCG_WAKE_SETTLE;
                     wake_cnt_ff <= '0;
                  end else begin
                     wake_cnt_ff <= wake_cnt_ff + 1'b1;
                  end
               end
            end
            MCG_WAKE_SETTLE: begin
               if (wake_cnt_ff == SETTLE_LAST) begin
                  wake_ff <= MCG_WAKE_RUN;
                  wake_cnt_ff <= '0;
               end else begin
                  wake_cnt_ff <= wake_cnt_ff + 1'b1;
               end
            end
            MCG_WAKE_RUN: begin
               wake_cnt_ff <= '0;
            end
            default: begin
               wake_ff <= MCG_WAKE_OSC;
               wake_cnt_ff <= '0;
            end
         endcase
      end
   end

   // divisor n gives 2n oscillator cycles per cpu clock, zero gives one
   always_comb begin
      if (divisor_ff == 8'h00) begin
         nxt_div_last = '0;
      end else begin
         nxt_div_last = MCG_DIV_CNT_W'({divisor_ff, 1'b0} - 9'h001);
      end
   end

   // cpu clock edge when the divider wraps and the gate is open
   assign cpu_core_clock_tick = osc_tick & (div_cnt_ff == div_last_ff) & (wake_ff == MCG_WAKE_RUN);

   // divider counter; new divisor taken only at a wrap so no short period occurs
   always_ff @(posedge clock_i) begin
      if (rst_i || warm_rst_i) begin
         div_cnt_ff <= '0;
         div_last_ff <= '0;
      end else if (osc_tick) begin
         if (div_cnt_ff == div_last_ff) begin
            div_cnt_ff <= '0;
            div_last_ff <= nxt_div_last;
         end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
         end
      end
   end

   // phase bit marks every second cpu clock as both a machine cycle and a peripheral clock
   always_ff @(posedge clock_i) begin
      if (rst_i || restart) begin
         cpu_core_clock_phase_ff <= 1'b0;
      end else if (cpu_core_clock_tick) begin
         cpu_core_clock_phase_ff <= ~cpu_core_clock_phase_ff;
      end
   end

   // clock output level toggles once per cpu clock
   always_ff @(posedge clock_i) begin
      if (rst_i || warm_rst_i) begin
         clkout_level_ff <= 1'b0;
      end else if (cpu_core_clock_tick) begin
         clkout_level_ff <= ~clkout_level_ff;
      end
   end

   // registered clock tick outputs
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         oscillator_clock_tick_o <= 1'b0;
         cpu_core_clock_tick_o <= 1'b0;
         machine_cycle_tick_o <= 1'b0;
         peripheral_tick_o <= 1'b0;
         cpu_clock_running_o <= 1'b0;
      end else begin
         oscillator_clock_tick_o <= osc_tick;
         cpu_core_clock_tick_o <= cpu_core_clock_tick;
         machine_cycle_tick_o <= cpu_core_clock_tick & cpu_core_clock_phase_ff;
         peripheral_tick_o <= cpu_core_clock_tick & cpu_core_clock_phase_ff;
         cpu_clock_running_o <= (wake_ff == MCG_WAKE_RUN);
      end
   end

   // divisor register, cleared by every reset source
   always_ff @(posedge clock_i) begin
      if (rst_i || warm_rst_i) begin
         divisor_ff <= MCG_DIVISOR_RST;
      end else if (req_i.wr && req_i.addr == MCG_DIVISOR_OFS) begin
         divisor_ff <= req_i.wdata;
      end
   end

   // trim register: factory value on power-on only, warm reset leaves it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         trim_ff <= factory_trim_i;
         clkout_en_ff <= MCG_TRIM_FLAGS_RST[0];
         rc_flag_ff <= MCG_TRIM_FLAGS_RST[1];
      end else if (req_i.wr && req_i.addr == MCG_TRIM_OFS) begin
         trim_ff <= req_i.wdata[MCG_TRIM_W-1:0];
         clkout_en_ff <= req_i.wdata[MCG_TRIM_CLKOUT_EN_BIT];
         rc_flag_ff <= req_i.wdata[MCG_TRIM_RC_BIT];
      end
   end

   // rc oscillator tuning value
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rc_trim_o <= '0;
      end else begin
         rc_trim_o <= trim_ff;
      end
   end

   // clock output only with crystal unused by both cpu and rtc
   assign clkout_allowed = clkout_en_ff & (cfg_ff.source != MCG_SRC_XTAL) & ~rtc_uses_crystal_i;

   // shared pin: clock output when allowed, ordinary port otherwise
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         clock_out_pin_o <= 1'b0;
         clock_out_pin_oe_o <= 1'b0;
      end else if (clkout_allowed) begin
         clock_out_pin_o <= clkout_level_ff;
         clock_out_pin_oe_o <= 1'b1;
      end else begin
         clock_out_pin_o <= port_pin_out_i;
         clock_out_pin_oe_o <= port_pin_oe_i;
      end
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      nxt_rdata = '0;
      unique case (req_i.addr)
         MCG_DIVISOR_OFS: begin
            nxt_rdata = divisor_ff;
         end
         MCG_TRIM_OFS: begin
            nxt_rdata = {rc_flag_ff, clkout_en_ff, trim_ff};
         end
         MCG_STATUS_OFS: begin
            nxt_rdata[MCG_ST_RUN_BIT] = (wake_ff == MCG_WAKE_RUN);
            nxt_rdata[MCG_ST_CLKOUT_BIT] = clkout_allowed;
            nxt_rdata[MCG_ST_WAKE_LSB +: 2] = wake_ff;
            nxt_rdata[MCG_ST_RTC_XTAL_BIT] = rtc_uses_crystal_i;
            nxt_rdata[MCG_ST_CPU_CORE_CLOCK_LVL_BIT] = src_level[cfg_ff.source];
         end
         MCG_CONFIG_OFS: begin
            nxt_rdata[MCG_CF_SRC_LSB +: 2] = cfg_ff.source;
            nxt_rdata[MCG_CF_RANGE_LSB +: 2] = cfg_ff.xtal_range;
            nxt_rdata[MCG_CF_RSTPIN_BIT] = cfg_ff.reset_pin_enable;
         end
         default: begin
            nxt_rdata = '0;
         end
      endcase
   end

   // read data stand for one cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         reg_rdata_o <= '0;
      end else if (req_i.rd) begin
         reg_rdata_o <= nxt_rdata;
      end else begin
         reg_rdata_o <= '0;
      end
   end
endmodule

// >>> pkg/mcg_pkg.sv
// shared constants, types and register map of the clock generation block
package mcg_pkg;

   // register port geometry
   localparam int MCG_ADDR_W = 4;
   localparam int MCG_DATA_W = 8;

   // register offsets
   localparam logic [3:0] MCG_DIVISOR_OFS = 4'h0;
   localparam logic [3:0] MCG_TRIM_OFS = 4'h1;
   localparam logic [3:0] MCG_STATUS_OFS = 4'h2;
   localparam logic [3:0] MCG_CONFIG_OFS = 4'h3;

   // values after reset
   localparam logic [7:0] MCG_DIVISOR_RST = 8'h00;
   localparam logic [1:0] MCG_TRIM_FLAGS_RST = 2'h0;

   // trim register fields
   localparam int MCG_TRIM_W = 6;
   localparam int MCG_TRIM_RC_BIT = 7;
   localparam int MCG_TRIM_CLKOUT_EN_BIT = 6;

   // status register fields
   localparam int MCG_ST_RUN_BIT = 0;
   localparam int MCG_ST_CLKOUT_BIT = 1;
   localparam int MCG_ST_WAKE_LSB = 2;
   localparam int MCG_ST_RTC_XTAL_BIT = 4;
   localparam int MCG_ST_CPU_CORE_CLOCK_LVL_BIT = 5;

   // config register fields
   localparam int MCG_CF_SRC_LSB = 0;
   localparam int MCG_CF_RANGE_LSB = 2;
   localparam int MCG_CF_RSTPIN_BIT = 4;

   // divider
   localparam int MCG_DIV_CNT_W = 9;
   localparam int MCG_MAX_DIVIDE = 510;

   // nominal frequencies in hertz
   localparam int MCG_RC_NOMINAL_HZ = 7373000;
   localparam int MCG_XTAL_LOW_MIN_HZ = 20000;
   localparam int MCG_XTAL_LOW_MAX_HZ = 100000;
   localparam int MCG_XTAL_MED_MAX_HZ = 4000000;
   localparam int MCG_XTAL_HIGH_MAX_HZ = 18000000;
   localparam int MCG_RESET_PIN_ABOVE_HZ = 12000000;

   // wake-up gating
   localparam int MCG_WAKE_XTAL_OSC_CYCLES = 992;
   localparam int MCG_WAKE_OTHER_OSC_CYCLES = 224;
   localparam int MCG_WAKE_SETTLE_MIN_NS = 60000;
   localparam int MCG_WAKE_SETTLE_MAX_NS = 100000;
   localparam int MCG_CLK_PERIOD_NS = 4;
   localparam int MCG_WAKE_SETTLE_CYCLES = (MCG_WAKE_SETTLE_MIN_NS + MCG_CLK_PERIOD_NS - 1) / MCG_CLK_PERIOD_NS;
   localparam int MCG_WAKE_CNT_W = 20;

   // oscillator clock sources, fixed at flash programming
   typedef enum logic [1:0] {
      MCG_SRC_WDOG = 2'b00,
      MCG_SRC_RC = 2'b01,
      MCG_SRC_XTAL = 2'b10,
      MCG_SRC_EXT = 2'b11
   } mcg_src_t;

   // crystal frequency ranges
   typedef enum logic [1:0] {
      MCG_RANGE_LOW = 2'b00,
      MCG_RANGE_MED = 2'b01,
      MCG_RANGE_HIGH = 2'b10
   } mcg_range_t;

   // wake-up sequencer states
   typedef enum logic [1:0] {
      MCG_WAKE_OSC = 2'b00,
      MCG_WAKE_SETTLE = 2'b01,
      MCG_WAKE_RUN = 2'b10
   } mcg_wake_t;

   // flash configuration word
   typedef struct packed {
      mcg_src_t source;
      mcg_range_t xtal_range;
      logic reset_pin_enable;
   } mcg_cfg_t;

   // register port request
   typedef struct packed {
      logic [MCG_ADDR_W-1:0] addr;
      logic [MCG_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } mcg_req_t;

endpackage

// >>> design/mcg_sync.sv
// two-stage synchronisers with rising-edge pulses for the oscillator inputs
`timescale 1ns/10ps
module mcg_sync #(
   parameter int W = 4
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o
);
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         logic meta_ff;
         logic sync_ff;
         logic prev_ff;
         logic rise_ff;
         // first stage feeds only the second stage
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= async_i[gi];
               sync_ff <= meta_ff;
            end
         end
         // edge detect on the settled level
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               prev_ff <= 1'b0;
               rise_ff <= 1'b0;
            end else begin
               prev_ff <= sync_ff;
               rise_ff <= sync_ff & ~prev_ff;
            end
         end
         assign level_o[gi] = prev_ff;
         assign rise_o[gi] = rise_ff;
      end
   endgenerate
endmodule

// >>> sim/mcg_clock_gen_chk.sv
// port assertions for the clock generation block
`timescale 1ns/10ps
module mcg_chk (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic warm_rst_i,
   input wire mcg_pkg::mcg_cfg_t cfg_i,
   input wire logic rtc_uses_crystal_i,
   input wire logic wake_i,
   input wire mcg_pkg::mcg_req_t req_i,
   input wire logic [mcg_pkg::MCG_DATA_W-1:0] reg_rdata_o,
   input wire logic port_pin_out_i,
   input wire logic port_pin_oe_i,
   input wire logic clock_out_pin_o,
   input wire logic clock_out_pin_oe_o,
   input wire logic cpu_core_clock_tick_o,
   input wire logic peripheral_tick_o,
   input wire logic machine_cycle_tick_o,
   input wire logic cpu_clock_running_o,
   input wire logic [mcg_pkg::MCG_TRIM_W-1:0] rc_trim_o
);
   import mcg_pkg::*;
   logic mc_last_ff;
   logic restart_d_ff;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // a cpu tick may still leave the cycle after a restart, from the old phase
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         restart_d_ff <= 1'b0;
      end else begin
         restart_d_ff <= warm_rst_i | wake_i;
      end
   end
   // remembers whether the last cpu tick closed a machine cycle
   always_ff @(posedge clock_i) begin
      if (rst_i || warm_rst_i || restart_d_ff) begin
         mc_last_ff <= 1'b1;
      end else if (cpu_core_clock_tick_o) begin
         mc_last_ff <= machine_cycle_tick_o;
      end
   end
   AST_RD_IDLE: assert property (!$past(req_i.rd) |-> reg_rdata_o == '0)
      else $error("read data not idle");
   AST_RD_UNMAPPED: assert property (req_i.rd && req_i.addr > MCG_CONFIG_OFS |=> reg_rdata_o == '0)
      else $error("unmapped read not zero");
   AST_RD_CONFIG: assert property (req_i.rd && req_i.addr == MCG_CONFIG_OFS |=>
      reg_rdata_o == {3'h0, $past(cfg_i.reset_pin_enable), $past(cfg_i.xtal_range), $past(cfg_i.source)})
      else $error("config read wrong");
   AST_RD_RTC: assert property (req_i.rd && req_i.addr == MCG_STATUS_OFS |=>
      reg_rdata_o[MCG_ST_RTC_XTAL_BIT] == $past(rtc_uses_crystal_i)) else $error("status rtc bit wrong");
   AST_TRIM_WARM: assert property (warm_rst_i && $past(warm_rst_i) |=> $stable(rc_trim_o))
      else $error("trim changed on warm reset");
   AST_PCLK_CPU: assert property (peripheral_tick_o |-> cpu_core_clock_tick_o && machine_cycle_tick_o)
      else $error("peripheral tick off cpu tick");
   AST_MC_ALT: assert property (cpu_core_clock_tick_o && !restart_d_ff |->
      machine_cycle_tick_o != mc_last_ff && peripheral_tick_o == machine_cycle_tick_o)
      else $error("machine cycle not every second cpu tick");
   AST_GATED_QUIET: assert property (!cpu_clock_running_o && !$past(cpu_clock_running_o)
      |-> !cpu_core_clock_tick_o) else $error("cpu tick while gated");
   AST_WAKE_GATE: assert property (wake_i |-> ##2 (!cpu_clock_running_o) [*8])
      else $error("gate not closed on wake");
   AST_WARM_GATE: assert property (warm_rst_i |-> ##2 !cpu_clock_running_o)
      else $error("gate open after warm reset");
   AST_PORT_MODE: assert property (!$past(rst_i) && !$past(warm_rst_i) && (cfg_i.source == MCG_SRC_XTAL
      || $past(rtc_uses_crystal_i, 2) && $past(rtc_uses_crystal_i)) |-> clock_out_pin_oe_o == $past(port_pin_oe_i)
      && clock_out_pin_o == $past(port_pin_out_i)) else $error("shared pin not in port mode");
endmodule
bind mcg_clock_gen mcg_chk u_chk (.clock_i, .rst_i, .warm_rst_i, .cfg_i, .rtc_uses_crystal_i, .wake_i, .req_i,
   .reg_rdata_o, .port_pin_out_i, .port_pin_oe_i, .clock_out_pin_o, .clock_out_pin_oe_o, .cpu_core_clock_tick_o,
   .peripheral_tick_o, .machine_cycle_tick_o, .cpu_clock_running_o, .rc_trim_o);

// >>> sim/mcg_osc_model.sv
// free-running oscillator sources facing the clock generation block
`timescale 1ns/10ps
module mcg_osc_model #(
   parameter int WDOG_HALF_NS = 18,
   parameter int RC_HALF_NS = 10,
   parameter int XTAL_HALF_NS = 12,
   parameter int EXT_HALF_NS = 16
) (
   output logic wdog_osc_o,
   output logic internal_rc_clock_o,
   output logic xtal_osc_o,
   output logic external_clock_in_pin_o
);
   // all sources start low; rates scaled to stay below a quarter of the system clock
   initial begin
      wdog_osc_o = 1'b0;
      internal_rc_clock_o = 1'b0;
      xtal_osc_o = 1'b0;
      external_clock_in_pin_o = 1'b0;
   end
   always #(WDOG_HALF_NS) wdog_osc_o = !wdog_osc_o;
   always #(RC_HALF_NS) internal_rc_clock_o = !internal_rc_clock_o;
   always #(XTAL_HALF_NS) xtal_osc_o = !xtal_osc_o;
   always #(EXT_HALF_NS) external_clock_in_pin_o = !external_clock_in_pin_o;
endmodule

// >>> sim/mcg_clock_gen_bench.sv
// self-checking bench for the clock generation block
`timescale 1ns/10ps
module mcg_clock_gen_bench;
   import mcg_pkg::*;
   localparam int SETTLE = 20;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic warm_rst_i = 1'b0;
   mcg_cfg_t cfg = '{MCG_SRC_RC, MCG_RANGE_LOW, 1'b0};
   logic [5:0] ftrim = 6'h2C;
   logic wdog, rc, xtal, ext, pin, pin_oe, osc_t, cpu_t, per_t, mc_t, run;
   logic rtc = 1'b0;
   logic wake = 1'b0;
   logic pout = 1'b1;
   logic poe = 1'b1;
   mcg_req_t req = '0;
   logic [7:0] rdata, d;
   logic [5:0] trim_o;
   logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};
   int miscompares = 0;
   int n_checks = 0;
   int n, p;
   mcg_osc_model u_osc (.wdog_osc_o(wdog), .internal_rc_clock_o(rc), .xtal_osc_o(xtal), .external_clock_in_pin_o(ext));
   mcg_clock_gen #(.WAKE_SETTLE_CYCLES(SETTLE)) u_dut (.clock_i, .rst_i, .warm_rst_i, .cfg_i(cfg),
      .factory_trim_i(ftrim), .wdog_osc_i(wdog), .internal_rc_clock_i(rc), .xtal_osc_i(xtal),
      .external_clock_in_pin_i(ext), .rtc_uses_crystal_i(rtc), .wake_i(wake), .req_i(req), .reg_rdata_o(rdata),
      .port_pin_out_i(pout), .port_pin_oe_i(poe), .clock_out_pin_o(pin), .clock_out_pin_oe_o(pin_oe),
      .oscillator_clock_tick_o(osc_t), .cpu_core_clock_tick_o(cpu_t), .peripheral_tick_o(per_t),
      .machine_cycle_tick_o(mc_t), .cpu_clock_running_o(run), .rc_trim_o(trim_o));
   // system clock
   always #2 clock_i = !clock_i;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_i);
      req <= '{a, v, 1'b1, 1'b0};
      @(posedge clock_i);
      req <= '0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_i);
      req <= '0;
      @(negedge clock_i);
      d = rdata;
      check(name, d, exp);
   endtask
   task automatic por(input mcg_src_t s, input mcg_range_t r, input logic rpe, input logic [5:0] ft);
      @(posedge clock_i);
      rst_i <= 1'b1;
      cfg <= '{s, r, rpe};
      ftrim <= ft;
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
   endtask
   // counts oscillator ticks until the cpu gate opens
   task automatic wake_chk(input int w);
      n = 0;
      for (int i = 0; i < 20000 && (i < 4 || !run); i++) begin
         @(negedge clock_i);
         if (osc_t === 1'b1) n++;
      end
      check("wake_ticks", n >= w - 1 && n <= w + 8, 1);
   endtask
   // oscillator ticks and pin changes over one cpu tick interval
   task automatic interval();
      logic last;
      n = 0;
      p = 0;
      for (int i = 0; i < 6000 && cpu_t !== 1'b1; i++) @(negedge clock_i);
      last = pin;
      do begin
         @(negedge clock_i);
         if (osc_t === 1'b1) n++;
         if (pin !== last) p++;
         last = pin;
      end while (cpu_t !== 1'b1 && n < 600);
   endtask
   initial begin
      #300000;
      miscompares++;
      stop_test();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      wake_chk(MCG_WAKE_OTHER_OSC_CYCLES);
      rdchk("div_rst", MCG_DIVISOR_OFS, MCG_DIVISOR_RST);
      rdchk("trim_por", MCG_TRIM_OFS, 8'h2C);
      rdchk("unmapped", 4'hF, 8'h00);
      wr(MCG_CONFIG_OFS, 8'hFF);
      rdchk("cfg_ro", MCG_CONFIG_OFS, 8'h01);
      // status bit 5 mirrors the live oscillator level, so it is masked out
      @(posedge clock_i);
      req <= '{MCG_STATUS_OFS, 8'h00, 1'b0, 1'b1};
      @(posedge clock_i);
      req <= '0;
      @(negedge clock_i);
      check("status", rdata & 8'hDF, 8'h09);
      foreach (divs[i]) begin
         wr(MCG_DIVISOR_OFS, divs[i]);
         interval();
         interval();
         check("div", n, divs[i] == 0 ? 1 : 2 * divs[i]);
      end
      wr(MCG_DIVISOR_OFS, 8'h01);
      wr(MCG_TRIM_OFS, 8'h6A);
      rdchk("trim_rw", MCG_TRIM_OFS, 8'h6A);
      check("rc_trim", trim_o, 6'h2A);
      interval();
      interval();
      check("clkout_oe", pin_oe, 1);
      check("clkout_half", p, 1);
      @(posedge clock_i);
      rtc <= 1'b1;
      pout <= 1'b0;
      interval();
      interval();
      check("rtc_port", {pin_oe, pin, p[3:0]}, 6'h20);
      @(posedge clock_i);
      rtc <= 1'b0;
      poe <= 1'b0;
      wr(MCG_TRIM_OFS, 8'h2A);
      interval();
      check("off_port", pin_oe, 0);
      wr(MCG_DIVISOR_OFS, 8'h03);
      @(posedge clock_i);
      warm_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      warm_rst_i <= 1'b0;
      wake_chk(MCG_WAKE_OTHER_OSC_CYCLES);
      rdchk("div_warm", MCG_DIVISOR_OFS, 8'h00);
      rdchk("trim_warm", MCG_TRIM_OFS, 8'h2A);
      @(posedge clock_i);
      wake <= 1'b1;
      @(posedge clock_i);
      wake <= 1'b0;
      wake_chk(MCG_WAKE_OTHER_OSC_CYCLES);
      for (int s = 0; s < 4; s++) begin
         por(mcg_src_t'(s), mcg_range_t'(s % 3), s == 2, 6'h15);
         wake_chk(s == 2 ? MCG_WAKE_XTAL_OSC_CYCLES : MCG_WAKE_OTHER_OSC_CYCLES);
         rdchk("cfg_src", MCG_CONFIG_OFS, {3'h0, s == 2, 2'(s % 3), 2'(s)});
         rdchk("trim_src", MCG_TRIM_OFS, 8'h15);
         wr(MCG_TRIM_OFS, 8'h55);
         repeat (4) @(negedge clock_i);
         check("clkout_src", pin_oe, s != 2);
      end
      stop_test();
   end
endmodule
